// ### hw/dcf_pkg.sv
// constants and types shared by the dual-clock flag and read control block
package dcf_pkg;
    localparam int DATA_W = 18;
    localparam int OFF_W = 12;
    localparam int ADDR_W = 12;
    localparam int CNT_W = 13;
    localparam int STAGE_DEPTH = 4;
    localparam int MEM_WORDS = 4096;
    // pin vector: 13 control pins followed by the write data
    localparam int CTL_W = 13;
    localparam int SYNC_W = CTL_W + DATA_W;
    // storage depth per width mode, output register adds one word in fall-through
    localparam logic [CNT_W-1:0] DEPTH_X18 = 13'h0800;
    localparam logic [CNT_W-1:0] DEPTH_X9 = 13'h1000;
    // serial offset length per width mode
    localparam logic [4:0] SER_LEN_X9 = 5'h0C;
    localparam logic [4:0] SER_LEN_OTHER = 5'h0B;
    // offsets after master reset
    localparam logic [OFF_W-1:0] EMPTY_OFF_RST = 12'h07F;
    localparam logic [OFF_W-1:0] FULL_OFF_RST = 12'h07F;
    typedef enum logic [1:0] {
        DCF_PH_RESET = 2'b01,
        DCF_PH_RUN = 2'b10
    } dcf_phase_t;
endpackage : dcf_pkg

// ### hw/dcf_stream_if.sv
// valid/ready word stream between the block's own modules
interface dcf_stream_if #(
    parameter int W = 18
);
    logic valid;
    logic ready;
    logic [W-1:0] data;
    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface : dcf_stream_if

// ### hw/dcf_mem.sv
// single-port word storage with registered read data
module dcf_mem #(
    parameter int WIDTH = 18,
    parameter int WORDS = 4096,
    parameter int AW = 12
) (
    input wire logic clk_in,
    input wire logic en_in,
    input wire logic we_in,
    input wire logic [AW-1:0] addr_in,
    input wire logic [WIDTH-1:0] wdata_in,
    output logic [WIDTH-1:0] rdata_out
);
    logic [WIDTH-1:0] mem_q [WORDS];
    logic [WIDTH-1:0] rdata_q;

    // no reset on the array: contents are only read after being written
    always_ff @(posedge clk_in) begin
        if (en_in && we_in) begin
            mem_q[addr_in] <= wdata_in;
        end
        if (en_in && !we_in) begin
            rdata_q <= mem_q[addr_in];
        end
    end

    assign rdata_out = rdata_q;
endmodule : dcf_mem

// ### hw/dcf_stage_fifo.sv
// small write-side staging fifo with valid/ready on both sides
module dcf_stage_fifo #(
    parameter int WIDTH = 18,
    parameter int DEPTH = 4
) (
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic clear_in,
    dcf_stream_if.snk push,
    dcf_stream_if.src pop
);
    localparam int PW = $clog2(DEPTH);
    logic [WIDTH-1:0] buf_q [DEPTH];
    logic [WIDTH-1:0] buf_d [DEPTH];
    logic [PW-1:0] wp_q, wp_d, rp_q, rp_d;
    logic [PW:0] cnt_q, cnt_d;
    logic do_push, do_pop;

    assign push.ready = (cnt_q != (PW+1)'(DEPTH));
    assign pop.valid = (cnt_q != '0);
    assign pop.data = buf_q[rp_q];

    always_comb begin
        do_push = push.valid && push.ready;
        do_pop = pop.valid && pop.ready;
        buf_d = buf_q;
        wp_d = wp_q;
        rp_d = rp_q;
        cnt_d = cnt_q;
        if (do_push) begin
            buf_d[wp_q] = push.data;
            wp_d = (wp_q == PW'(DEPTH - 1)) ? '0 : wp_q + 1'b1;
        end
        if (do_pop) begin
            rp_d = (rp_q == PW'(DEPTH - 1)) ? '0 : rp_q + 1'b1;
        end
        if (do_push && !do_pop) begin
            cnt_d = cnt_q + 1'b1;
        end else if (do_pop && !do_push) begin
            cnt_d = cnt_q - 1'b1;
        end
        if (clear_in) begin
            wp_d = '0;
            rp_d = '0;
            cnt_d = '0;
        end
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            wp_q <= '0;
            rp_q <= '0;
            cnt_q <= '0;
        end else begin
            wp_q <= wp_d;
            rp_q <= rp_d;
            cnt_q <= cnt_d;
        end
    end

    always_ff @(posedge clk_in) begin
        buf_q <= buf_d;
    end
endmodule : dcf_stage_fifo

// ### hw/dcf_flag_ctrl.sv
// fifo status flags, read control and offset programming
module dcf_flag_ctrl (
    input wire logic mclk_in,
    input wire logic rst_n_in,
    input wire logic master_reset_n_in,
    input wire logic partial_reset_n_in,
    input wire logic write_enable_n_in,
    input wire logic write_chip_select_n_in,
    input wire logic [dcf_pkg::DATA_W-1:0] write_data_in,
    input wire logic read_enable_n_in,
    input wire logic read_chip_select_n_in,
    input wire logic output_enable_n_in,
    input wire logic offset_load_select_n_in,
    input wire logic serial_enable_n_in,
    input wire logic serial_data_in,
    input wire logic fall_through_mode_in,
    input wire logic flag_timing_select_in,
    input wire logic nine_bit_mode_in,
    output logic full_flag_n_out,
    output logic empty_flag_n_out,
    output logic almost_full_flag_n_out,
    output logic almost_empty_flag_n_out,
    output logic [dcf_pkg::DATA_W-1:0] read_data_out,
    output logic read_data_oe_out
);
    import dcf_pkg::*;

    // every pin except the clock and rst_n_in crosses two flops before use
    logic [SYNC_W-1:0] sync1_q, sync2_q;
    logic mrst_n, prst_n, wen_n, wcs_n, ren_n, rcs_n, oe_n, ld_n, sen_n, sdat;
    logic fall_through_mode_pin, pfm_pin, nine_pin;
    logic [DATA_W-1:0] wdata;

    always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            sync1_q <= '0;
            sync2_q <= '0;
        end else begin
            sync1_q <= {master_reset_n_in, partial_reset_n_in, write_enable_n_in,
                        write_chip_select_n_in, read_enable_n_in, read_chip_select_n_in,
                        output_enable_n_in, offset_load_select_n_in, serial_enable_n_in,
                        serial_data_in, fall_through_mode_in, flag_timing_select_in,
                        nine_bit_mode_in, write_data_in};
            sync2_q <= sync1_q;
        end
    end
    assign {mrst_n, prst_n, wen_n, wcs_n, ren_n, rcs_n, oe_n, ld_n, sen_n, sdat,
            fall_through_mode_pin, pfm_pin, nine_pin, wdata} = sync2_q;

    dcf_phase_t phase_q, phase_d;
    logic fall_through_mode_q, fall_through_mode_d, pfm_q, pfm_d, nine_q, nine_d;
    logic [OFF_W-1:0] eoff_q, eoff_d, foff_q, foff_d;
    logic [2*OFF_W-1:0] ser_q, ser_d, len_mask;
    logic [5:0] scnt_q, scnt_d, ser_last;
    logic [4:0] ser_len;
    logic pl_sel_q, pl_sel_d, pr_sel_q, pr_sel_d;
    logic [ADDR_W-1:0] wptr_q, wptr_d, rptr_q, rptr_d;
    logic [CNT_W-1:0] total_q, total_d, mcnt_q, mcnt_d, cap, cnt_all;
    logic pend_q, pend_d, outv_q, outv_d;
    logic full_n_q, full_n_d, empty_n_q, empty_n_d, af_n_q, af_n_d, ae_n_q, ae_n_d;
    logic [DATA_W-1:0] dout_q, dout_d;
    logic oe_q, oe_d;
    logic run, wr_evt, accept, fetch, drain, pop, off_wr, off_rd, ser_evt, af_hit, ae_hit;
    logic [DATA_W-1:0] mem_rdata;

    dcf_stream_if #(.W(DATA_W)) stg_in ();
    dcf_stream_if #(.W(DATA_W)) stg_out ();

    function automatic logic [ADDR_W-1:0] ptr_next(input logic [ADDR_W-1:0] p,
                                                    input logic [CNT_W-1:0] c);
        ptr_next = ({1'b0, p} == c - 13'h0001) ? '0 : ADDR_W'(p + 1'b1);
    endfunction : ptr_next

    assign run = (phase_q == DCF_PH_RUN);
    assign cap = nine_q ? DEPTH_X9 : DEPTH_X18;
    assign stg_in.valid = wr_evt;
    assign stg_in.data = wdata;
    // single-port storage: reads take the port, staging fifo waits and may fill
    assign stg_out.ready = run && !fetch && (mcnt_q < cap);

    dcf_stage_fifo #(.WIDTH(DATA_W), .DEPTH(STAGE_DEPTH)) u_stage (
        .clk_in(mclk_in),
        .rst_n_in(rst_n_in),
        .clear_in(!run),
        .push(stg_in),
        .pop(stg_out)
    );

    dcf_mem #(.WIDTH(DATA_W), .WORDS(MEM_WORDS), .AW(ADDR_W)) u_mem (
        .clk_in(mclk_in),
        .en_in(fetch || drain),
        .we_in(drain),
        .addr_in(fetch ? rptr_q : wptr_q),
        .wdata_in(stg_out.data),
        .rdata_out(mem_rdata)
    );

    always_comb begin
        phase_d = (!mrst_n || !prst_n) ? DCF_PH_RESET : DCF_PH_RUN;
        // modes are caught while master reset is held
        fall_through_mode_d = !mrst_n ? fall_through_mode_pin : fall_through_mode_q;
        pfm_d = !mrst_n ? pfm_pin : pfm_q;
        nine_d = !mrst_n ? nine_pin : nine_q;

        wr_evt = run && !wen_n && !wcs_n && ld_n && full_n_q;
        accept = wr_evt && stg_in.ready;
        drain = stg_out.valid && stg_out.ready;
        pop = fall_through_mode_q && outv_q && !ren_n && !rcs_n && ld_n;
        if (fall_through_mode_q) begin
            // first word moves forward without enable or select
            fetch = run && (mcnt_q != '0) && !pend_q && (!outv_q || pop);
        end else begin
            fetch = run && !ren_n && !rcs_n && ld_n && (mcnt_q != '0);
        end
        off_wr = run && !ld_n && !wen_n && !wcs_n;
        off_rd = run && !ld_n && !ren_n && !rcs_n;
        ser_evt = run && !ld_n && !sen_n;

        wptr_d = drain ? ptr_next(wptr_q, cap) : wptr_q;
        rptr_d = fetch ? ptr_next(rptr_q, cap) : rptr_q;
        total_d = CNT_W'(total_q + {12'h000, accept} - {12'h000, fetch});
        mcnt_d = CNT_W'(mcnt_q + {12'h000, drain} - {12'h000, fetch});
        pend_d = fetch;

        dout_d = dout_q;
        outv_d = outv_q;
        if (pend_q) begin
            dout_d = mem_rdata;
            outv_d = fall_through_mode_q;
        end else if (pop) begin
            outv_d = 1'b0;
        end
        // offset read-back; back-to-back reads are not guarded
        pr_sel_d = pr_sel_q;
        if (off_rd) begin
            dout_d = DATA_W'(pr_sel_q ? foff_q : eoff_q);
            pr_sel_d = !pr_sel_q;
        end

        // offsets: parallel load overwrites, empty then full
        eoff_d = eoff_q;
        foff_d = foff_q;
        pl_sel_d = pl_sel_q;
        if (off_wr) begin
            if (pl_sel_q) begin
                foff_d = wdata[OFF_W-1:0];
            end else begin
                eoff_d = wdata[OFF_W-1:0];
            end
            pl_sel_d = !pl_sel_q;
        end
        ser_len = nine_q ? SER_LEN_X9 : SER_LEN_OTHER;
        ser_last = 6'({ser_len, 1'b0} - 6'h01);
        len_mask = ~({(2*OFF_W){1'b1}} << ser_len);
        ser_d = ser_q;
        scnt_d = scnt_q;
        if (ser_evt) begin
            ser_d[scnt_q[4:0]] = sdat;
            if (scnt_q == ser_last) begin
                // empty offset first, full offset in the next field
                eoff_d = OFF_W'(ser_d & len_mask);
                foff_d = OFF_W'((ser_d >> ser_len) & len_mask);
                scnt_d = '0;
            end else begin
                scnt_d = scnt_q + 6'h01;
            end
        end

        // full and empty computed from next counts, so they move on the same edge as the counts
        if (fall_through_mode_q) begin
            full_n_d = !((total_d == cap) && outv_d) && stg_in.ready;
            // no empty blip when the next word is already fetched behind a read
            empty_n_d = outv_d || (pend_d && outv_q);
        end else begin
            full_n_d = (total_d != cap) && stg_in.ready;
            empty_n_d = (mcnt_d != '0);
        end
        cnt_all = CNT_W'(total_d + {12'h000, fall_through_mode_q && (outv_d || pend_d)});
        af_hit = ({1'b0, cnt_all} >= ({1'b0, cap} + {13'h0000, fall_through_mode_q}
                 - {2'b00, foff_q}));
        ae_hit = (cnt_all <= {1'b0, eoff_q});
        if (pfm_q) begin
            af_n_d = !af_hit;
            ae_n_d = !ae_hit;
        end else begin
            // asynchronous style: set by one side, released only by the other
            af_n_d = af_n_q;
            ae_n_d = ae_n_q;
            if (accept && af_hit) begin
                af_n_d = 1'b0;
            end else if ((fetch || pop) && !af_hit) begin
                af_n_d = 1'b1;
            end
            if ((fetch || pop) && ae_hit) begin
                ae_n_d = 1'b0;
            end else if (accept && !ae_hit) begin
                ae_n_d = 1'b1;
            end
        end

        // chip select only counts from the first edge after reset release
        if (phase_d == DCF_PH_RESET) begin
            oe_d = !oe_n;
        end else begin
            oe_d = !oe_n && !rcs_n;
        end

        // partial reset keeps modes and offsets, master reset also loads offsets with EMPTY_OFF_RST and FULL_OFF_RST
        if (!run) begin
            wptr_d = '0;
            rptr_d = '0;
            total_d = '0;
            mcnt_d = '0;
            pend_d = 1'b0;
            outv_d = 1'b0;
            dout_d = '0;
            full_n_d = 1'b1;
            empty_n_d = 1'b0;
            af_n_d = 1'b1;
            ae_n_d = 1'b0;
            pl_sel_d = 1'b0;
            pr_sel_d = 1'b0;
            ser_d = '0;
            scnt_d = '0;
        end
        if (!mrst_n) begin
            eoff_d = EMPTY_OFF_RST;
            foff_d = FULL_OFF_RST;
        end
    end

    always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            phase_q <= DCF_PH_RESET;
            fall_through_mode_q <= 1'b0;
            pfm_q <= 1'b0;
            nine_q <= 1'b0;
            eoff_q <= EMPTY_OFF_RST;
            foff_q <= FULL_OFF_RST;
            ser_q <= '0;
            scnt_q <= '0;
            pl_sel_q <= 1'b0;
            pr_sel_q <= 1'b0;
            wptr_q <= '0;
            rptr_q <= '0;
            total_q <= '0;
            mcnt_q <= '0;
            pend_q <= 1'b0;
            outv_q <= 1'b0;
            full_n_q <= 1'b1;
            empty_n_q <= 1'b0;
            af_n_q <= 1'b1;
            ae_n_q <= 1'b0;
            dout_q <= '0;
            oe_q <= 1'b0;
        end else begin
            phase_q <= phase_d;
            fall_through_mode_q <= fall_through_mode_d;
            pfm_q <= pfm_d;
            nine_q <= nine_d;
            eoff_q <= eoff_d;
            foff_q <= foff_d;
            ser_q <= ser_d;
            scnt_q <= scnt_d;
            pl_sel_q <= pl_sel_d;
            pr_sel_q <= pr_sel_d;
            wptr_q <= wptr_d;
            rptr_q <= rptr_d;
            total_q <= total_d;
            mcnt_q <= mcnt_d;
            pend_q <= pend_d;
            outv_q <= outv_d;
            full_n_q <= full_n_d;
            empty_n_q <= empty_n_d;
            af_n_q <= af_n_d;
            ae_n_q <= ae_n_d;
            dout_q <= dout_d;
            oe_q <= oe_d;
        end
    end

    assign full_flag_n_out = full_n_q;
    assign empty_flag_n_out = empty_n_q;
    assign almost_full_flag_n_out = af_n_q;
    assign almost_empty_flag_n_out = ae_n_q;
    assign read_data_out = dout_q;
    assign read_data_oe_out = oe_q;
endmodule : dcf_flag_ctrl

// ### testbench/dcf_reader_model.sv
// reader-side partner model driving read enable and read chip select
module dcf_reader_model (
    input wire logic mclk_in,
    input wire logic rst_n_in,
    input wire logic rd_req_in,
    input wire logic cs_keep_in,
    output logic read_enable_n_out,
    output logic read_chip_select_n_out
);
    timeunit 1ns;
    timeprecision 1ps;
    logic pend_q;
    always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            pend_q <= 1'h0;
            read_enable_n_out <= 1'h1;
            read_chip_select_n_out <= 1'h1;
        end else begin
            // select must already sit low, and enable never low twice running
            if (pend_q && !read_chip_select_n_out && read_enable_n_out) begin
                read_enable_n_out <= 1'h0;
                pend_q <= 1'h0;
            end else begin
                read_enable_n_out <= 1'h1;
                pend_q <= pend_q | rd_req_in;
            end
            read_chip_select_n_out <= !(cs_keep_in || rd_req_in || pend_q);
        end
    end
endmodule : dcf_reader_model

// ### testbench/dcf_flag_ctrl_properties.sv
// concurrent checks on the flag and read control ports
module dcf_flag_ctrl_chk (
    input wire logic mclk_in,
    input wire logic rst_n_in,
    input wire logic master_reset_n_in,
    input wire logic partial_reset_n_in,
    input wire logic write_enable_n_in,
    input wire logic write_chip_select_n_in,
    input wire logic read_enable_n_in,
    input wire logic read_chip_select_n_in,
    input wire logic output_enable_n_in,
    input wire logic full_flag_n_out,
    input wire logic empty_flag_n_out,
    input wire logic almost_full_flag_n_out,
    input wire logic almost_empty_flag_n_out,
    input wire logic [dcf_pkg::DATA_W-1:0] read_data_out,
    input wire logic read_data_oe_out
);
    import dcf_pkg::*;
    logic [3:0] wr_age_q, wr_age_d, rd_age_q, rd_age_d, qt_q, qt_d;
    // ages saturate so long idle spans never wrap into a false cause
    always_comb begin
        wr_age_d = wr_age_q + {3'h0, wr_age_q != 4'hF};
        rd_age_d = rd_age_q + {3'h0, rd_age_q != 4'hF};
        qt_d = qt_q + {3'h0, qt_q != 4'hF};
        if (!write_enable_n_in && !write_chip_select_n_in) wr_age_d = 4'h0;
        if (!read_enable_n_in && !read_chip_select_n_in) rd_age_d = 4'h0;
        if (!master_reset_n_in || !partial_reset_n_in) qt_d = 4'h0;
    end
    always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            wr_age_q <= 4'hF;
            rd_age_q <= 4'hF;
            qt_q <= 4'h0;
        end else begin
            wr_age_q <= wr_age_d;
            rd_age_q <= rd_age_d;
            qt_q <= qt_d;
        end
    end
    default clocking cb @(posedge mclk_in);
    endclocking
    default disable iff (!rst_n_in);
    sequence s_mr_oe;
        (!master_reset_n_in && !output_enable_n_in && read_chip_select_n_in) [*4];
    endsequence
    sequence s_pr_oe;
        (!partial_reset_n_in && !output_enable_n_in && read_chip_select_n_in) [*4];
    endsequence
    AST_MR_OE: assert property (s_mr_oe |-> read_data_oe_out)
        else $error("data drive lost during master reset");
    AST_PR_OE: assert property (s_pr_oe |-> read_data_oe_out)
        else $error("data drive lost during partial reset");
    AST_FULL_REL: assert property ($rose(full_flag_n_out) && qt_q > 4'h5 |-> rd_age_q < 4'h8)
        else $error("full released without a recent read");
    AST_EMPTY_REL: assert property ($rose(empty_flag_n_out) && qt_q > 4'h5 |-> wr_age_q < 4'h8)
        else $error("empty released without a recent write");
    AST_PAF_SET: assert property ($fell(almost_full_flag_n_out) |-> wr_age_q < 4'h8)
        else $error("almost full set without a recent write");
    AST_PAF_REL: assert property ($rose(almost_full_flag_n_out) && qt_q > 4'h5
        |-> rd_age_q < 4'h8)
        else $error("almost full released without a recent read");
    AST_PAE_REL: assert property ($rose(almost_empty_flag_n_out) && qt_q > 4'h5
        |-> wr_age_q < 4'h8)
        else $error("almost empty released without a recent write");
    AST_DATA_SRC: assert property ($changed(read_data_out) && qt_q > 4'h5
        |-> rd_age_q < 4'h8 || wr_age_q < 4'h8)
        else $error("output register changed with no read or write");
endmodule : dcf_flag_ctrl_chk
bind dcf_flag_ctrl dcf_flag_ctrl_chk u_chk (.mclk_in(mclk_in), .rst_n_in(rst_n_in),
    .master_reset_n_in(master_reset_n_in), .partial_reset_n_in(partial_reset_n_in),
    .write_enable_n_in(write_enable_n_in), .write_chip_select_n_in(write_chip_select_n_in),
    .read_enable_n_in(read_enable_n_in), .read_chip_select_n_in(read_chip_select_n_in),
    .output_enable_n_in(output_enable_n_in), .full_flag_n_out(full_flag_n_out),
    .empty_flag_n_out(empty_flag_n_out), .almost_full_flag_n_out(almost_full_flag_n_out),
    .almost_empty_flag_n_out(almost_empty_flag_n_out), .read_data_out(read_data_out),
    .read_data_oe_out(read_data_oe_out));

// ### testbench/dcf_flag_ctrl_tb_top.sv
// self-checking bench for the flag and read control block
module dcf_flag_ctrl_tb_top;
    import dcf_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic mclk, rst_n, mr_n, pr_n, wen_n, wcs_n, ren_n, rcs_n, oe_n, ld_n, sen_n, sd;
    logic ft, fts, x9, rd_req, cs_keep, ff_n, ef_n, paf_n, pae_n, qoe;
    logic [17:0] wd, q;
    logic fts_sel;
    int errors, n_tests;
    dcf_flag_ctrl DUT (.mclk_in(mclk), .rst_n_in(rst_n), .master_reset_n_in(mr_n),
        .partial_reset_n_in(pr_n), .write_enable_n_in(wen_n), .write_chip_select_n_in(wcs_n),
        .write_data_in(wd), .read_enable_n_in(ren_n), .read_chip_select_n_in(rcs_n),
        .output_enable_n_in(oe_n), .offset_load_select_n_in(ld_n), .serial_enable_n_in(sen_n),
        .serial_data_in(sd), .fall_through_mode_in(ft), .flag_timing_select_in(fts),
        .nine_bit_mode_in(x9), .full_flag_n_out(ff_n), .empty_flag_n_out(ef_n),
        .almost_full_flag_n_out(paf_n), .almost_empty_flag_n_out(pae_n),
        .read_data_out(q), .read_data_oe_out(qoe));
    dcf_reader_model u_rd (.mclk_in(mclk), .rst_n_in(rst_n), .rd_req_in(rd_req),
        .cs_keep_in(cs_keep), .read_enable_n_out(ren_n), .read_chip_select_n_out(rcs_n));
    initial begin
        mclk = 1'h0;
        forever #2.5 mclk = ~mclk;
    end
    task automatic stop_test();
        if (errors == 0 && n_tests > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : stop_test
    task automatic tk(input int n);
        repeat (n) @(posedge mclk);
    endtask : tk
    task automatic chk(input logic [17:0] g, input logic [17:0] e);
        n_tests++;
        if (g !== e) begin
            errors++;
            $display("BAD %0t got %h expected %h", $time, g, e);
        end
    endtask : chk
    task automatic wr(input int n, input logic [17:0] b);
        for (int i = 0; i < n; i++) begin
            wen_n <= 1'h0;
            wd <= b + 18'(i);
            @(posedge mclk);
        end
        wen_n <= 1'h1;
        @(posedge mclk);
    endtask : wr
    // one read through the partner, then time for two synchroniser flops
    task automatic rd();
        rd_req <= 1'h1;
        @(posedge mclk);
        rd_req <= 1'h0;
        tk(10);
    endtask : rd
    task automatic mreset(input logic f, input logic x);
        mr_n <= 1'h0;
        ft <= f;
        x9 <= x;
        fts <= fts_sel;
        oe_n <= 1'h0;
        tk(6);
        chk(qoe, 1'h1);
        mr_n <= 1'h1;
        tk(6);
        chk(qoe, 1'h0);
    endtask : mreset
    task automatic ofs_wr(input logic [11:0] e, input logic [11:0] f);
        ld_n <= 1'h0;
        wr(1, {6'h00, e});
        wr(1, {6'h00, f});
        ld_n <= 1'h1;
        @(posedge mclk);
    endtask : ofs_wr
    task automatic ofs_rd(input logic [11:0] e, input logic [11:0] f);
        ld_n <= 1'h0;
        rd();
        chk(q[11:0], e);
        rd();
        chk(q[11:0], f);
        ld_n <= 1'h1;
    endtask : ofs_rd
    task automatic t_pr();
        mreset(1'h0, 1'h0);
        wr(2, 18'h00011);
        tk(8);
        pr_n <= 1'h0;
        tk(6);
        chk(qoe, 1'h1);
        pr_n <= 1'h1;
        tk(6);
        chk(ef_n, 1'h0);
        chk(qoe, 1'h0);
    endtask : t_pr
    task automatic t_ofs();
        mreset(1'h0, 1'h0);
        ofs_wr(12'h0F0, 12'h7F0);
        ofs_wr(12'h003, 12'h005);
        wr(3, 18'h00100);
        tk(8);
        chk(pae_n, 1'h0);
        wr(1, 18'h00103);
        tk(8);
        chk(pae_n, 1'h1);
        chk(ef_n, 1'h1);
        chk(q, 18'h00000);
        rd();
        chk(q, 18'h00100);
        ofs_rd(12'h003, 12'h005);
    endtask : t_ofs
    task automatic t_ft();
        mreset(1'h1, 1'h0);
        wr(1, 18'h2A5A5);
        tk(10);
        chk(ef_n, 1'h1);
        chk(q, 18'h2A5A5);
        wr(1, 18'h15A5A);
        tk(10);
        chk(q, 18'h2A5A5);
        rd();
        chk(q, 18'h15A5A);
    endtask : t_ft
    task automatic t_ser(input logic x, input int n, input logic [11:0] e, input logic [11:0] f);
        mreset(1'h0, x);
        ld_n <= 1'h0;
        for (int i = 0; i < 2 * n; i++) begin
            sen_n <= 1'h0;
            sd <= (i < n) ? e[i] : f[i-n];
            @(posedge mclk);
        end
        sen_n <= 1'h1;
        tk(4);
        ofs_rd(e, f);
    endtask : t_ser
    // fills up to the documented depth; default offsets stay in place
    task automatic t_fill(input logic f, input logic x, input int d);
        mreset(f, x);
        wr(d - 128, 18'h00000);
        tk(8);
        chk(paf_n, 1'h1);
        wr(1, 18'h00000);
        tk(8);
        chk(paf_n, 1'h0);
        wr(126, 18'h00000);
        tk(8);
        chk(ff_n, 1'h1);
        wr(1, 18'h00000);
        tk(8);
        chk(ff_n, 1'h0);
        wr(1, 18'h3FFFF);
        rd();
        chk(ff_n, 1'h1);
        repeat (127) rd();
        chk(paf_n, 1'h1);
    endtask : t_fill
    // async flags hold when the offset moves; only the far side releases them
    task automatic t_async();
        fts_sel = 1'h0;
        mreset(1'h0, 1'h0);
        ofs_wr(12'h001, 12'h7FE);
        wr(2, 18'h00200);
        tk(8);
        chk(paf_n, 1'h0);
        chk(pae_n, 1'h1);
        ofs_wr(12'h001, 12'h07F);
        tk(8);
        chk(paf_n, 1'h0);
        rd();
        chk(paf_n, 1'h1);
        chk(pae_n, 1'h0);
    endtask : t_async
    initial begin
        errors = 0;
        n_tests = 0;
        {rst_n, sd, ft, x9, rd_req, cs_keep, wcs_n} = 7'h00;
        {mr_n, pr_n, wen_n, oe_n, ld_n, sen_n, fts} = 7'h7F;
        wd = 18'h00000;
        fts_sel = 1'h1;
        tk(6);
        rst_n <= 1'h1;
        tk(2);
        t_pr();
        t_ofs();
        t_ft();
        t_ser(1'h0, 11, 12'h40A, 12'h40B);
        t_ser(1'h1, 12, 12'h80A, 12'h80B);
        t_fill(1'h0, 1'h0, int'(DEPTH_X18));
        t_fill(1'h1, 1'h0, int'(DEPTH_X18) + 1);
        t_fill(1'h0, 1'h1, int'(DEPTH_X9));
        t_async();
        stop_test();
    end
    // about 13k cycles expected; six times that means a hang
    initial begin
        #400000;
        errors++;
        stop_test();
    end
endmodule : dcf_flag_ctrl_tb_top
